/* osru_pkg.sv */
// Package with constants and types for the OTP security register unit
package osru_pkg;
	localparam int OSRU_ROWS = 2048;
	localparam int OSRU_SECTOR_ROWS = 512;
	localparam int OSRU_ADDR_W = 11;
	localparam int OSRU_DATA_W = 32;
	localparam int OSRU_ROW_W = 9;
	localparam int OSRU_SECURITY_ROW = 0;
	localparam logic [31:0] OSRU_SECURITY_RESET = 32'h00000000;
	localparam int OSRU_BIT_NO_DEBUG = 0;
	localparam int OSRU_BIT_NO_LINK = 1;
	localparam int OSRU_BIT_SECURE_BOOT = 5;
	localparam int OSRU_BIT_REDUNDANT = 7;
	localparam int OSRU_BIT_LOCK0 = 8;
	localparam int OSRU_BIT_MASTER_LOCK = 12;
	localparam int OSRU_BIT_NO_DEBUG_OTP = 13;
	localparam int OSRU_BIT_NO_SYNC_PIN = 14;
	localparam int OSRU_GP_LSB = 15;
	localparam int OSRU_GP_MSB = 21;
	localparam int OSRU_UID_LSB = 22;
	localparam int OSRU_UID_MSB = 31;
	localparam logic [11:0] OSRU_OFF_SECURITY = 12'h000;
	localparam logic [11:0] OSRU_OFF_PROG_ADDR = 12'h004;
	localparam logic [11:0] OSRU_OFF_PROG_DATA = 12'h008;
	localparam logic [11:0] OSRU_OFF_PROG_CTRL = 12'h00c;
	localparam logic [11:0] OSRU_OFF_STATUS = 12'h010;
	localparam logic [11:0] OSRU_OFF_USERCODE = 12'h014;
	localparam logic [11:0] OSRU_OFF_DBG_ADDR = 12'h018;
	localparam logic [11:0] OSRU_OFF_DBG_DATA = 12'h01c;
	localparam logic [31:0] OSRU_RESOURCE_ADDR_PORT = 32'h00100200;
	localparam logic [31:0] OSRU_RESOURCE_DATA_PORT = 32'h00200100;
	localparam logic [31:0] OSRU_RESOURCE_CTRL_PORT = 32'h00100300;
	localparam int OSRU_CTRL_PROG = 0;
	localparam int OSRU_CTRL_DBG_READ = 1;
	localparam logic [1:0] OSRU_RESP_OKAY = 2'b00;
	localparam logic [1:0] OSRU_RESP_SLVERR = 2'b10;
	localparam int OSRU_SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		OSRU_LOAD_SEC = 2'b00,
		OSRU_COPY = 2'b01,
		OSRU_RUN = 2'b11
	} osru_boot_e;
endpackage

/* osru_mem_if.sv */
// Interface carrying OTP array accesses between the unit and its array
`timescale 1ns/1ps
interface osru_mem_if;
	logic [osru_pkg::OSRU_ADDR_W-1:0] addr;
	logic [osru_pkg::OSRU_DATA_W-1:0] wdata;
	logic we;
	logic [osru_pkg::OSRU_DATA_W-1:0] rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport array (input addr, input wdata, input we, output rdata);
endinterface

/* osru_array.sv */
// OTP array storage, bits only ever go from zero to one
`timescale 1ns/1ps
module osru_array (
	input wire logic aclk,
	input wire logic ce,
	osru_mem_if.array mem
);
	import osru_pkg::*;
	// Unprogrammed cells read as zero; set here so only the clocked process writes them
	logic [OSRU_DATA_W-1:0] cells [OSRU_ROWS] = '{default: '0};
	logic [OSRU_DATA_W-1:0] rdata_reg;
	// One-time programmable: a write can only set bits, never clear them
	always_ff @(posedge aclk) begin
		if (ce) begin
			if (mem.we) begin
				cells[mem.addr] <= cells[mem.addr] | mem.wdata;
			end
			rdata_reg <= cells[mem.addr];
		end
	end
	assign mem.rdata = rdata_reg;
endmodule

/* osru_sync.sv */
// Three-stage synchroniser for a pin input with agreement filter
`timescale 1ns/1ps
module osru_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic pin_in,
	output logic level
);
	import osru_pkg::*;
	logic [OSRU_SYNC_STAGES-1:0] stage_reg;
	logic [OSRU_SYNC_STAGES-1:0] stage_next;
	logic level_reg;
	logic level_next;
	always_comb begin
		stage_next = {stage_reg[OSRU_SYNC_STAGES-2:0], pin_in};
		level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
	end
	// Pin idles high when pulled up, so reset to one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage_reg <= '1;
			level_reg <= 1'b1;
		end else if (ce) begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end
	assign level = level_reg;
endmodule

/* osru_top.sv */
// OTP security register unit: boot load, locks, programming and AXI4-Lite registers
//
// Overview of operation
// - Four lockable sectors of 512 32-bit rows.
// - Load security word from OTP before use.
// - Copy remaining OTP to SRAM, then run.
// - Bit 0 blocks all debug access.
// - Bit 1 blocks link access from tiles.
// - Bit 5 boots from OTP address zero.
// - Bit 7 enables redundant rows.
// - Bits 8-11 lock sectors 0-3.
// - Bit 12 blocks all programming.
// - Bit 13 blocks debug OTP reads; programming is not gated by it.
// - Bit 14 ignores, never drives sync pin.
// - Bits 21:15 readable general-purpose field.
// - Bits 31:22 extend debug user code.
// - User code from top ten bits.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module osru_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic debug_req,
	input wire logic link_req,
	input wire logic dbg_sync_in,
	output logic dbg_sync_out,
	output logic dbg_sync_oe_n,
	input wire logic debug_halt,
	output logic debug_grant,
	output logic link_grant,
	output logic redundant_en,
	output logic boot_from_otp,
	output logic [osru_pkg::OSRU_ADDR_W-1:0] boot_pc,
	output logic sram_we,
	output logic [osru_pkg::OSRU_ADDR_W-1:0] sram_addr,
	output logic [31:0] sram_wdata,
	output logic cpu_start,
	output logic [31:0] usercode
);
	import osru_pkg::*;

	osru_mem_if mem ();
	osru_array u_array (
		.aclk(aclk),
		.ce(ce),
		.mem(mem)
	);
	logic sync_level;
	osru_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.pin_in(dbg_sync_in),
		.level(sync_level)
	);
	// Sector of a row comes from the upper address bits
	function automatic logic [1:0] sector_of(input logic [OSRU_ADDR_W-1:0] a);
		sector_of = a[OSRU_ADDR_W-1:OSRU_ROW_W];
	endfunction
	function automatic logic locked(input logic [31:0] sec, input logic [OSRU_ADDR_W-1:0] a);
		logic [1:0] s;
		s = sector_of(a);
		locked = sec[OSRU_BIT_MASTER_LOCK] | sec[OSRU_BIT_LOCK0 + int'(s)];
	endfunction
	// Boot sequencer and security register
	osru_boot_e boot_reg, boot_next;
	logic [OSRU_ADDR_W-1:0] cnt_reg, cnt_next;
	logic rd_wait_reg, rd_wait_next;
	logic [31:0] sec_reg, sec_next;
	logic sram_we_reg, sram_we_next;
	logic [OSRU_ADDR_W-1:0] sram_addr_reg, sram_addr_next;
	logic [31:0] sram_wdata_reg, sram_wdata_next;
	// Programming registers
	logic [15:0] paddr_reg, paddr_next;
	logic [31:0] pdata_reg, pdata_next;
	logic [15:0] pctrl_reg, pctrl_next;
	logic prog_fire_reg, prog_fire_next;
	logic dbg_rd_fire_reg, dbg_rd_fire_next;
	logic rd_pend_reg, rd_pend_next;
	logic [31:0] dbg_data_reg, dbg_data_next;
	logic rejected_reg, rejected_next;
	logic done_reg, done_next;
	// AXI state
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	logic [11:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic running;
	logic dbg_otp_ok;
	logic wr_go;
	logic [31:0] wmask;
	logic [31:0] rd_val;
	logic rd_hit;
	// Features open one cycle late so the last copied row is out before the processor starts
	assign running = (boot_reg == OSRU_RUN) && !sram_we_reg;
	assign dbg_otp_ok = running && !sec_reg[OSRU_BIT_NO_DEBUG] && !sec_reg[OSRU_BIT_NO_DEBUG_OTP];
	assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
		end
	end
	// Read decode
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr[11:0])
			OSRU_OFF_SECURITY: rd_val = sec_reg;
			OSRU_OFF_PROG_ADDR: rd_val = {16'h0000, paddr_reg};
			OSRU_OFF_PROG_DATA: rd_val = pdata_reg;
			OSRU_OFF_PROG_CTRL: rd_val = {16'h0000, pctrl_reg};
			OSRU_OFF_STATUS: rd_val = {27'h0, rd_pend_reg, rejected_reg, done_reg, boot_reg};
			OSRU_OFF_USERCODE: rd_val = usercode;
			OSRU_OFF_DBG_DATA: rd_val = dbg_data_reg;
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		boot_next = boot_reg;
		cnt_next = cnt_reg;
		rd_wait_next = 1'b0;
		sec_next = sec_reg;
		sram_we_next = 1'b0;
		sram_addr_next = sram_addr_reg;
		sram_wdata_next = sram_wdata_reg;
		paddr_next = paddr_reg;
		pdata_next = pdata_reg;
		pctrl_next = pctrl_reg;
		prog_fire_next = 1'b0;
		dbg_rd_fire_next = 1'b0;
		rd_pend_next = rd_pend_reg;
		dbg_data_next = dbg_data_reg;
		rejected_next = rejected_reg;
		done_next = done_reg;
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		mem.addr = cnt_reg;
		mem.wdata = pdata_reg;
		mem.we = 1'b0;

		// Boot: read each row; row 0 feeds the security register, the rest go to SRAM
		unique case (boot_reg)
			OSRU_LOAD_SEC: begin
				mem.addr = OSRU_ADDR_W'(OSRU_SECURITY_ROW);
				rd_wait_next = !rd_wait_reg;
				if (rd_wait_reg) begin
					sec_next = mem.rdata;
					boot_next = OSRU_COPY;
					cnt_next = OSRU_ADDR_W'(OSRU_SECURITY_ROW + 1);
				end
			end
			OSRU_COPY: begin
				mem.addr = cnt_reg;
				rd_wait_next = 1'b1;
				if (rd_wait_reg) begin
					sram_we_next = 1'b1;
					sram_addr_next = cnt_reg - OSRU_ADDR_W'(1);
					sram_wdata_next = mem.rdata;
					rd_wait_next = 1'b0;
					if (cnt_reg == OSRU_ADDR_W'(OSRU_ROWS - 1)) begin
						boot_next = OSRU_RUN;
					end else begin
						cnt_next = cnt_reg + OSRU_ADDR_W'(1);
					end
				end
			end
			OSRU_RUN: begin
				mem.addr = paddr_reg[OSRU_ADDR_W-1:0];
				if (prog_fire_reg) begin
					// A locked request never reaches the array
					if (locked(sec_reg, paddr_reg[OSRU_ADDR_W-1:0])) begin
						rejected_next = 1'b1;
					end else begin
						mem.we = 1'b1;
						done_next = 1'b1;
					end
				end
				if (dbg_rd_fire_reg) begin
					rd_pend_next = 1'b1;
				end
				if (rd_pend_reg) begin
					dbg_data_next = mem.rdata;
					rd_pend_next = 1'b0;
				end
			end
		endcase

		// AXI write channels taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr[11:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = OSRU_RESP_OKAY;
			unique case (awaddr_reg)
				OSRU_OFF_PROG_ADDR: paddr_next = (paddr_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
				OSRU_OFF_PROG_DATA: pdata_next = (pdata_reg & ~wmask) | (wdata_reg & wmask);
				OSRU_OFF_PROG_CTRL: begin
					pctrl_next = (pctrl_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
					if (wstrb_reg[0] && wdata_reg[OSRU_CTRL_PROG] && running) begin
						prog_fire_next = 1'b1;
					end
					if (wstrb_reg[0] && wdata_reg[OSRU_CTRL_DBG_READ]) begin
						if (dbg_otp_ok) begin
							dbg_rd_fire_next = 1'b1;
						end else begin
							bresp_next = OSRU_RESP_SLVERR;
						end
					end
				end
				OSRU_OFF_STATUS: begin
					// Write one to clear; a same-cycle event still wins
					if (wstrb_reg[0] && wdata_reg[2]) done_next = 1'b0;
					if (wstrb_reg[0] && wdata_reg[3]) rejected_next = 1'b0;
					if (prog_fire_reg && locked(sec_reg, paddr_reg[OSRU_ADDR_W-1:0]) && running) rejected_next = 1'b1;
					if (prog_fire_reg && !locked(sec_reg, paddr_reg[OSRU_ADDR_W-1:0]) && running) done_next = 1'b1;
				end
				OSRU_OFF_SECURITY, OSRU_OFF_USERCODE, OSRU_OFF_DBG_DATA: bresp_next = OSRU_RESP_OKAY;
				default: bresp_next = OSRU_RESP_SLVERR;
			endcase
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next = rd_val;
			rresp_next = rd_hit ? OSRU_RESP_OKAY : OSRU_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_reg <= OSRU_LOAD_SEC;
			cnt_reg <= '0;
			rd_wait_reg <= 1'b0;
			sec_reg <= OSRU_SECURITY_RESET;
			sram_we_reg <= 1'b0;
			sram_addr_reg <= '0;
			sram_wdata_reg <= '0;
			paddr_reg <= '0;
			pdata_reg <= '0;
			pctrl_reg <= '0;
			prog_fire_reg <= 1'b0;
			dbg_rd_fire_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			dbg_data_reg <= '0;
			rejected_reg <= 1'b0;
			done_reg <= 1'b0;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= OSRU_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= OSRU_RESP_OKAY;
		end else if (ce) begin
			boot_reg <= boot_next;
			cnt_reg <= cnt_next;
			rd_wait_reg <= rd_wait_next;
			sec_reg <= sec_next;
			sram_we_reg <= sram_we_next;
			sram_addr_reg <= sram_addr_next;
			sram_wdata_reg <= sram_wdata_next;
			paddr_reg <= paddr_next;
			pdata_reg <= pdata_next;
			pctrl_reg <= pctrl_next;
			prog_fire_reg <= prog_fire_next;
			dbg_rd_fire_reg <= dbg_rd_fire_next;
			rd_pend_reg <= rd_pend_next;
			dbg_data_reg <= dbg_data_next;
			rejected_reg <= rejected_next;
			done_reg <= done_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Single outstanding write and read; ready drops while a response waits
	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Features stay closed until the security word is loaded and, except the user code, until the last row has been copied to SRAM
	assign debug_grant = running && debug_req && !sec_reg[OSRU_BIT_NO_DEBUG];
	assign link_grant = running && link_req && !sec_reg[OSRU_BIT_NO_LINK];
	assign redundant_en = running && sec_reg[OSRU_BIT_REDUNDANT];
	assign boot_from_otp = running && sec_reg[OSRU_BIT_SECURE_BOOT];
	assign boot_pc = '0;
	assign cpu_start = running;
	assign sram_we = sram_we_reg;
	assign sram_addr = sram_addr_reg;
	assign sram_wdata = sram_wdata_reg;
	assign usercode = {sec_reg[OSRU_UID_MSB:OSRU_UID_LSB], 22'h000000};

	// Sync pin is open drain: pull low on a halt unless disabled
	logic sync_en;
	assign sync_en = running && !sec_reg[OSRU_BIT_NO_SYNC_PIN];
	assign dbg_sync_out = 1'b0;
	assign dbg_sync_oe_n = !(sync_en && debug_halt);
	logic sync_halt_req_unused;
	assign sync_halt_req_unused = sync_en && !sync_level;
endmodule

/* osru_top_asserts.sv */
// Port assertions for the OTP security register unit
`timescale 1ns/1ps
module osru_top_asserts
	import osru_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic debug_req,
	input wire logic link_req,
	input wire logic debug_halt,
	input wire logic debug_grant,
	input wire logic link_grant,
	input wire logic redundant_en,
	input wire logic boot_from_otp,
	input wire logic [osru_pkg::OSRU_ADDR_W-1:0] boot_pc,
	input wire logic dbg_sync_out,
	input wire logic dbg_sync_oe_n,
	input wire logic sram_we,
	input wire logic [osru_pkg::OSRU_ADDR_W-1:0] sram_addr,
	input wire logic cpu_start,
	input wire logic [31:0] usercode
);
	// Frozen cycles would stretch every count, so ce low suspends checking
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	sequence s_copy_row;
		sram_we && !cpu_start && sram_addr != 11'h7fe;
	endsequence
	sequence s_last_row;
		sram_we && sram_addr == 11'h7fe;
	endsequence
	a_debug_gate: assert property (debug_grant |-> debug_req && cpu_start)
		else $error("debug grant without request or before run");
	a_link_gate: assert property (link_grant |-> link_req && cpu_start)
		else $error("link grant without request or before run");
	a_secure_boot: assert property (boot_from_otp |-> cpu_start && boot_pc == 11'h0)
		else $error("secure boot outside run or nonzero start");
	a_redundant_run: assert property (redundant_en |-> cpu_start)
		else $error("redundant rows enabled before run");
	a_sync_pin_off: assert property (!dbg_sync_oe_n |-> debug_halt && cpu_start && !dbg_sync_out)
		else $error("sync pin driven without cause");
	a_usercode_low: assert property (usercode[21:0] == 22'h0)
		else $error("user code low field not zero");
	a_security_hold: assert property (cpu_start && $past(cpu_start) |-> $stable(usercode) && $stable(boot_from_otp))
		else $error("security outputs changed while running");
	a_copy_step: assert property (s_copy_row |-> ##2 sram_we && sram_addr == $past(sram_addr, 2) + 11'h1)
		else $error("copy rows out of step");
	a_copy_done: assert property (s_last_row |-> ##[1:8] cpu_start)
		else $error("no start after last row");
	a_run_no_copy: assert property (cpu_start |-> !sram_we)
		else $error("copy write while running");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule
bind osru_top osru_top_asserts osru_top_asserts_i (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .debug_req,
	.link_req, .debug_halt, .debug_grant, .link_grant, .redundant_en, .boot_from_otp, .boot_pc, .dbg_sync_out,
	.dbg_sync_oe_n, .sram_we, .sram_addr, .cpu_start, .usercode);

/* osru_top_test.sv */
// Self-checking bench for the OTP security register unit
`timescale 1ns/1ps
module osru_top_test;
	import osru_pkg::*;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, sram_wdata, usercode;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic debug_req = 0, link_req = 0, debug_halt = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, dbg_sync_out, dbg_sync_oe_n, debug_grant, link_grant;
	logic redundant_en, boot_from_otp, sram_we, cpu_start;
	logic [1:0] s_axi_bresp, s_axi_rresp, bres, rres;
	logic [10:0] boot_pc, sram_addr;
	logic [31:0] mdl [2048];
	logic [31:0] w1, w2, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	int checks = 0, miscompares = 0, copies = 0;
	always #12.5 aclk = ~aclk;
	osru_top osru_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .debug_req, .link_req, .dbg_sync_in(1'b1), .dbg_sync_out, .dbg_sync_oe_n,
		.debug_halt, .debug_grant, .link_grant, .redundant_en, .boot_from_otp, .boot_pc, .sram_we, .sram_addr,
		.sram_wdata, .cpu_start, .usercode);
	task automatic summarize();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, m, seen, exp);
		end
	endtask
	// Row 0 holds the security word and is never copied
	always @(posedge aclk) begin
		if (aresetn && ce && sram_we) begin
			copies++;
			chk(sram_wdata, mdl[sram_addr + 11'h1], "copied row");
		end
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		summarize();
	end
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= {20'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (s_axi_awready && !ta) begin
				ta = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready && !tw) begin
				tw = 1;
				s_axi_wvalid <= 0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		bres = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= {20'h0, a};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rres = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic boot();
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		copies = 0;
		aresetn <= 1;
		// Freeze the copy just after a row write; nothing may move while ce is low
		repeat (100) @(posedge aclk);
		while (!sram_we) @(posedge aclk);
		ce <= 0;
		@(posedge aclk);
		v = 32'(sram_addr);
		repeat (6) @(posedge aclk);
		chk(32'(sram_addr), v, "frozen copy");
		ce <= 1;
		while (!cpu_start) @(posedge aclk);
		chk(32'(copies), 32'd2047, "rows copied");
	endtask
	task automatic prog(input int row, input logic [31:0] d, input logic rej);
		axw(OSRU_OFF_STATUS, 32'hc);
		axw(OSRU_OFF_PROG_ADDR, 32'(row));
		axw(OSRU_OFF_PROG_DATA, d);
		axw(OSRU_OFF_PROG_CTRL, 32'h1);
		repeat (8) @(posedge aclk);
		axr(OSRU_OFF_STATUS);
		chk(32'(v[3]), 32'(rej), "program refusal");
		chk(32'(v[2]), 32'(!rej), "program done");
		if (!rej)
			mdl[row] = mdl[row] | d;
	endtask
	// Debug read back; a refused program must leave the row as it was
	task automatic peek(input int row);
		axw(OSRU_OFF_PROG_ADDR, 32'(row));
		axw(OSRU_OFF_PROG_CTRL, 32'h2);
		repeat (4) @(posedge aclk);
		do axr(OSRU_OFF_STATUS); while (v[4]);
		axr(OSRU_OFF_DBG_DATA);
		chk(v, mdl[row], "array row");
	endtask
	initial begin
		void'($urandom(32'h4ab0));
		foreach (mdl[i]) mdl[i] = 32'h0;
		w1 = ($urandom() & 32'hffff8000) | 32'h000006a0;
		w2 = 32'h00007003;
		boot();
		axr(OSRU_OFF_SECURITY);
		chk(v, 32'h0, "blank security");
		chk(usercode, 32'h0, "blank user code");
		axr(OSRU_OFF_STATUS);
		chk(32'(v[1:0]), 32'h3, "boot state");
		axr(12'h020);
		chk(32'(rres), 32'(OSRU_RESP_SLVERR), "unmapped read");
		axw(OSRU_OFF_SECURITY, 32'hffffffff);
		axr(OSRU_OFF_SECURITY);
		chk(v, 32'h0, "read-only security");
		axw(OSRU_OFF_PROG_DATA, 32'h11223344);
		s_axi_wstrb <= 4'h2;
		axw(OSRU_OFF_PROG_DATA, 32'h0000ab00);
		s_axi_wstrb <= 4'hf;
		axr(OSRU_OFF_PROG_DATA);
		chk(v, 32'h1122ab44, "byte strobe merge");
		for (int i = 0; i < 5; i++) begin
			int row;
			row = 1 + int'($urandom % 2047);
			prog(row, $urandom, 1'b0);
			peek(row);
		end
		prog(0, w1, 1'b0);
		boot();
		axr(OSRU_OFF_SECURITY);
		chk(v, w1, "loaded security");
		debug_req <= 1;
		link_req <= 1;
		debug_halt <= 1;
		repeat (2) @(posedge aclk);
		chk(usercode, {w1[31:22], 22'h0}, "user code");
		chk(32'({boot_from_otp, redundant_en, debug_grant, link_grant, dbg_sync_oe_n}), 32'h1e, "features on");
		chk(32'(boot_pc), 32'h0, "boot start");
		for (int s = 0; s < 4; s++) begin
			prog(s * 512 + 511, $urandom, s == 1 || s == 2);
			peek(s * 512 + 511);
			prog(s * 512 + int'(s == 0), $urandom, s == 1 || s == 2);
			peek(s * 512 + int'(s == 0));
		end
		prog(0, w2, 1'b0);
		boot();
		axr(OSRU_OFF_SECURITY);
		chk(v, w1 | w2, "merged security");
		chk(32'({debug_grant, link_grant, dbg_sync_oe_n}), 32'h1, "features off");
		prog(100, $urandom, 1'b1);
		axw(OSRU_OFF_PROG_CTRL, 32'h2);
		chk(32'(bres), 32'(OSRU_RESP_SLVERR), "debug read denied");
		summarize();
	end
endmodule
